//--- logic/bcg_pkg.sv
// Constants and carrier types for the branch clock manager.
// Assumes a single 100 MHz register clock and an AXI4-Lite master.
package bcg_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_BRANCH = 8;
  localparam int unsigned NUM_BASE   = 3;
  localparam int unsigned ADDR_W     = 8;

  // ---------------------------------------------------------------
  // Branch indices
  // ---------------------------------------------------------------
  localparam int unsigned BR_SAFE    = 0;
  localparam int unsigned BR_CPU     = 1;
  localparam int unsigned BR_SYS     = 2;
  localparam int unsigned BR_PCR     = 3;
  localparam int unsigned BR_PCRSLOW = 4;

  // Fixed base clock of each branch: 0 safe, 1 system, 2 power control
  localparam logic [1:0] BASE_SAFE = 2'h0;
  localparam logic [1:0] BASE_SYS  = 2'h1;
  localparam logic [1:0] BASE_PCR  = 2'h2;
  // Power control branch 3 draws on the system base; only branch 4 uses base 2
  localparam logic [NUM_BRANCH*2-1:0] BRANCH_BASE_MAP =
    {BASE_SYS, BASE_SYS, BASE_SYS, BASE_PCR, BASE_SYS, BASE_SYS, BASE_SYS, BASE_SAFE};

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_POWER_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WAKE_EVENT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BASE_STAT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CFG_BASE   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STAT_BASE  = 8'h60;
  localparam int unsigned       CFG_IDX_LSB    = 2;
  localparam int unsigned       CFG_IDX_W      = 3;

  // Config register fields
  localparam int unsigned FLD_RUN  = 0;
  localparam int unsigned FLD_AUTO = 1;
  localparam int unsigned FLD_WAKE = 2;
  localparam int unsigned FLD_POWER_DOWN = 0;

  // Tie-off masks per branch: bit = 1 means field is fixed
  localparam logic [NUM_BRANCH-1:0] RUN_FIXED  = 8'h1F;
  localparam logic [NUM_BRANCH-1:0] RUN_VALUE  = 8'h1F;
  localparam logic [NUM_BRANCH-1:0] AUTO_FIXED = 8'h01;
  localparam logic [NUM_BRANCH-1:0] WAKE_FIXED = 8'h01;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BR_ON    = 2'b00,
    BR_HSK   = 2'b01,
    BR_OFF   = 2'b10
  } bcg_branch_state_t;

  typedef struct packed {
    logic run;
    logic autom;
    logic wake;
  } bcg_cfg_t;

  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  aw_held;
    logic [ADDR_W-1:0]     aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } bcg_bus_t;

  typedef struct packed {
    bcg_bus_t                              bus;
    bcg_cfg_t [NUM_BRANCH-1:0]             cfg;
    bcg_branch_state_t [NUM_BRANCH-1:0]    st;
    logic                                  power_down_bit;
    logic [NUM_BRANCH-1:0]                 clk_en;
    logic [NUM_BRANCH-1:0]                 mdis_req;
    logic [NUM_BASE-1:0]                   base_idle;
  } bcg_state_t;

endpackage : bcg_pkg

//--- logic/bcg_branch_clock_manager.sv
// Branch clock manager: per-branch clock enables with run/auto/wake bits.
// Assumes clock gate cells downstream consume clk_en_out, and bus masters
// answer mdis_req_out with mdis_ack_in in the AXI4-Lite clock domain.
module bcg_branch_clock_manager
  import bcg_pkg::*;
(
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic [ADDR_W-1:0]     awaddr_in,
  input  wire logic                  awvalid_in,
  output logic                       awready_out,
  input  wire logic [31:0]           wdata_in,
  input  wire logic [3:0]            wstrb_in,
  input  wire logic                  wvalid_in,
  output logic                       wready_out,
  output logic [1:0]                 bresp_out,
  output logic                       bvalid_out,
  input  wire logic                  bready_in,
  input  wire logic [ADDR_W-1:0]     araddr_in,
  input  wire logic                  arvalid_in,
  output logic                       arready_out,
  output logic [31:0]                rdata_out,
  output logic [1:0]                 rresp_out,
  output logic                       rvalid_out,
  input  wire logic                  rready_in,
  input  wire logic                  wake_event_in,
  input  wire logic [NUM_BRANCH-1:0] mdis_ack_in,
  output logic [NUM_BRANCH-1:0]      clk_en_out,
  output logic [NUM_BRANCH-1:0]      mdis_req_out,
  output logic [NUM_BASE-1:0]        base_idle_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Apply tie-offs so fixed bits never hold a written value
  function automatic bcg_cfg_t tie_cfg(input bcg_cfg_t c, input int unsigned i);
    bcg_cfg_t r;
    r = c;
    if (RUN_FIXED[i]) r.run = RUN_VALUE[i];
    if (AUTO_FIXED[i]) r.autom = 1'b0;
    if (WAKE_FIXED[i]) r.wake = 1'b0;
    return r;
  endfunction : tie_cfg

  function automatic logic [1:0] base_of(input int unsigned i);
    return BRANCH_BASE_MAP[i*2 +: 2];
  endfunction : base_of

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] cfg_word(input bcg_cfg_t c);
    logic [31:0] r;
    r = READ_ZERO;
    r[FLD_RUN]  = c.run;
    r[FLD_AUTO] = c.autom;
    r[FLD_WAKE] = c.wake;
    return r;
  endfunction : cfg_word

  // New config bits after a write, tie-offs applied
  function automatic bcg_cfg_t cfg_update(input bcg_cfg_t old, input logic [31:0] d,
                                          input logic [3:0] s, input int unsigned i);
    logic [31:0] w;
    bcg_cfg_t    c;
    w       = merge(cfg_word(old), d, s);
    c       = '0;
    c.run   = w[FLD_RUN];
    c.autom = w[FLD_AUTO];
    c.wake  = w[FLD_WAKE];
    return tie_cfg(c, i);
  endfunction : cfg_update

  // Config window: one word per branch
  function automatic logic in_cfg_win(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:CFG_IDX_LSB+CFG_IDX_W] ==
           OFS_CFG_BASE[ADDR_W-1:CFG_IDX_LSB+CFG_IDX_W];
  endfunction : in_cfg_win

  // Status window: read-only enable per branch
  function automatic logic in_stat_win(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:CFG_IDX_LSB+CFG_IDX_W] ==
           OFS_STAT_BASE[ADDR_W-1:CFG_IDX_LSB+CFG_IDX_W];
  endfunction : in_stat_win

  // Branch number within either window
  function automatic logic [CFG_IDX_W-1:0] branch_idx(input logic [ADDR_W-1:0] a);
    return a[CFG_IDX_LSB +: CFG_IDX_W];
  endfunction : branch_idx

  // Demand for a branch clock; power-down holds back branches without
  // wake, and the safe branch never stops
  function automatic logic branch_wanted(input bcg_cfg_t c, input logic pd,
                                         input int unsigned i);
    if (i == BR_SAFE) return 1'h1;
    return c.run && !(pd && !c.wake);
  endfunction : branch_wanted

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  bcg_state_t state;
  bcg_state_t next_state;

  always_comb begin
    logic        wr_go;
    logic [31:0] wv;
    logic [31:0] rv;
    logic [1:0]  rr;
    logic        want_on;
    logic        all_off;
    wr_go      = 1'b0;
    wv         = READ_ZERO;
    rv         = READ_ZERO;
    rr         = RESP_OKAY;
    want_on    = 1'b0;
    all_off    = 1'b0;
    next_state = state;

    // -------------------------------------------------------------
    // Write channel: address and data in either order
    // -------------------------------------------------------------
    if (awvalid_in && state.bus.awready) begin
      next_state.bus.aw_held = 1'b1;
      next_state.bus.aw_addr = awaddr_in;
      next_state.bus.awready = 1'b0;
    end
    if (wvalid_in && state.bus.wready) begin
      next_state.bus.w_held = 1'b1;
      next_state.bus.w_data = wdata_in;
      next_state.bus.w_strb = wstrb_in;
      next_state.bus.wready = 1'b0;
    end
    if (state.bus.aw_held && state.bus.w_held && !state.bus.bvalid) begin
      wr_go                  = 1'b1;
      next_state.bus.aw_held = 1'b0;
      next_state.bus.w_held  = 1'b0;
      next_state.bus.bvalid  = 1'b1;
      next_state.bus.bresp   = RESP_SLVERR;
    end
    if (state.bus.bvalid && bready_in) begin
      next_state.bus.bvalid  = 1'b0;
      next_state.bus.awready = 1'b1;
      next_state.bus.wready  = 1'b1;
    end

    if (wr_go) begin
      if (state.bus.aw_addr == OFS_POWER_MODE) begin
        wv = merge({31'h0, state.power_down_bit}, state.bus.w_data, state.bus.w_strb);
        next_state.power_down_bit = wv[FLD_POWER_DOWN];
        next_state.bus.bresp      = RESP_OKAY;
      end else if (state.bus.aw_addr == OFS_WAKE_EVENT) begin
        next_state.bus.bresp = RESP_OKAY;
      end else if (state.bus.aw_addr == OFS_BASE_STAT) begin
        next_state.bus.bresp = RESP_OKAY;
      end else if (in_cfg_win(state.bus.aw_addr)) begin
        for (int i = 0; i < NUM_BRANCH; i++) begin
          if (branch_idx(state.bus.aw_addr) == CFG_IDX_W'(i)) begin
            next_state.cfg[i] = cfg_update(state.cfg[i], state.bus.w_data,
                                           state.bus.w_strb, i);
          end
        end
        next_state.bus.bresp = RESP_OKAY;
      end
    end

    // -------------------------------------------------------------
    // Branch gating
    // -------------------------------------------------------------
    for (int i = 0; i < NUM_BRANCH; i++) begin
      // Power-down stops branches without wake bit, other than the safe branch
      want_on = branch_wanted(state.cfg[i], state.power_down_bit, i);
      case (state.st[i])
        BR_ON: begin
          if (!want_on) begin
            if (state.cfg[i].autom) begin
              next_state.st[i]       = BR_HSK;
              next_state.mdis_req[i] = 1'b1;
            end else begin
              next_state.st[i] = BR_OFF;
            end
          end
        end
        BR_HSK: begin
          // Clock keeps running until the master lets go
          if (want_on) begin
            next_state.st[i]       = BR_ON;
            next_state.mdis_req[i] = 1'b0;
          end else if (mdis_ack_in[i]) begin
            next_state.st[i]       = BR_OFF;
            next_state.mdis_req[i] = 1'b0;
          end
        end
        BR_OFF: begin
          // Restart on demand or on a wake event
          if (want_on || (wake_event_in && state.cfg[i].run && state.cfg[i].wake)) begin
            next_state.st[i] = BR_ON;
          end
        end
        default: begin
          next_state.st[i] = BR_ON;
        end
      endcase
      next_state.clk_en[i] = (next_state.st[i] != BR_OFF);
    end
    // Wake event clears power-down so woken branches stay on
    if (wake_event_in) next_state.power_down_bit = 1'b0;

    // -------------------------------------------------------------
    // Base clock status
    // -------------------------------------------------------------
    for (int b = 0; b < NUM_BASE; b++) begin
      all_off = 1'b1;
      for (int i = 0; i < NUM_BRANCH; i++) begin
        if (base_of(i) == 2'(b) && next_state.clk_en[i]) all_off = 1'b0;
      end
      next_state.base_idle[b] = all_off;
    end

    // -------------------------------------------------------------
    // Read channel
    // -------------------------------------------------------------
    if (arvalid_in && state.bus.arready) begin
      if (araddr_in == OFS_POWER_MODE) begin
        rv = {31'h0, state.power_down_bit};
      end else if (araddr_in == OFS_WAKE_EVENT) begin
        rv = READ_ZERO;
      end else if (araddr_in == OFS_BASE_STAT) begin
        rv = {29'h0, state.base_idle};
      end else if (in_cfg_win(araddr_in)) begin
        rv = cfg_word(state.cfg[branch_idx(araddr_in)]);
      end else if (in_stat_win(araddr_in)) begin
        rv = {31'h0, state.clk_en[branch_idx(araddr_in)]};
      end else begin
        rr = RESP_SLVERR;
      end
      next_state.bus.arready = 1'b0;
      next_state.bus.rvalid  = 1'b1;
      next_state.bus.rdata   = rv;
      next_state.bus.rresp   = rr;
    end
    if (state.bus.rvalid && rready_in) begin
      next_state.bus.rvalid  = 1'b0;
      next_state.bus.arready = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Register update
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // All branches run, bus channels ready
      state             <= '0;
      state.bus.awready <= 1'b1;
      state.bus.wready  <= 1'b1;
      state.bus.arready <= 1'b1;
      for (int i = 0; i < NUM_BRANCH; i++) begin
        state.cfg[i].run <= 1'b1;
        state.st[i]      <= BR_ON;
      end
      state.clk_en      <= '1;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign awready_out   = state.bus.awready;
  assign wready_out    = state.bus.wready;
  assign bvalid_out    = state.bus.bvalid;
  assign bresp_out     = state.bus.bresp;
  assign arready_out   = state.bus.arready;
  assign rvalid_out    = state.bus.rvalid;
  assign rdata_out     = state.bus.rdata;
  assign rresp_out     = state.bus.rresp;
  assign clk_en_out    = state.clk_en;
  assign mdis_req_out  = state.mdis_req;
  assign base_idle_out = state.base_idle;

endmodule : bcg_branch_clock_manager

//--- bench/bcg_checker_assertions.sv
// Concurrent checks on the branch clock manager ports.
// Assumes binding to bcg_branch_clock_manager in one clock domain.
module bcg_checker
  import bcg_pkg::*;
(
  input wire logic                  ref_clk_in,
  input wire logic                  rst_b_in,
  input wire logic                  awvalid_in,
  input wire logic                  awready_out,
  input wire logic                  wvalid_in,
  input wire logic                  wready_out,
  input wire logic [1:0]            bresp_out,
  input wire logic                  bvalid_out,
  input wire logic                  bready_in,
  input wire logic                  arvalid_in,
  input wire logic                  arready_out,
  input wire logic [31:0]           rdata_out,
  input wire logic                  rvalid_out,
  input wire logic                  rready_in,
  input wire logic [NUM_BRANCH-1:0] clk_en_out,
  input wire logic [NUM_BRANCH-1:0] mdis_req_out,
  input wire logic [NUM_BASE-1:0]   base_idle_out
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  read_hold_a:
    assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
    else $error("read data not held");
  write_hold_a:
    assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
    else $error("write response not held");
  read_busy_a:
    assert property (rvalid_out |-> !arready_out) else $error("read taken while busy");
  write_busy_a:
    assert property (bvalid_out |-> !awready_out && !wready_out)
    else $error("write taken while busy");
  read_latency_a:
    assert property (arvalid_in && arready_out |=> rvalid_out) else $error("read answer late");
  write_latency_a:
    assert property (awvalid_in && awready_out && wvalid_in && wready_out
                     |=> !bvalid_out ##1 bvalid_out) else $error("write answer timing");
  safe_no_hsk_a:
    assert property (!mdis_req_out[BR_SAFE]) else $error("safe branch handshake");
  safe_always_on_a:
    assert property (clk_en_out[BR_SAFE]) else $error("safe branch stopped");
  hsk_keeps_clock_a:
    assert property ((mdis_req_out & ~clk_en_out) == '0) else $error("clock stopped in handshake");
  base_idle_map_a:
    assert property (base_idle_out == {~clk_en_out[4], ~|{clk_en_out[7:5], clk_en_out[3:1]},
                                       ~clk_en_out[0]}) else $error("base idle mismatch");
endmodule : bcg_checker

//--- bench/bcg_master_model.sv
// Bus masters that answer master-disable requests.
// Assumes the manager's clock; odd branches answer slowly.
module bcg_master_model
  import bcg_pkg::*;
#(
  parameter int SLOW_DLY = 6
)
(
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic [NUM_BRANCH-1:0] mdis_req_in,
  output logic [NUM_BRANCH-1:0]      mdis_ack_out
);
  timeunit 1ns;
  timeprecision 100ps;

  int wait_cnt [NUM_BRANCH];

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    for (int i = 0; i < NUM_BRANCH; i++) begin
      if (!rst_b_in || !mdis_req_in[i]) begin
        wait_cnt[i] <= 0;
        mdis_ack_out[i] <= 1'h0;
      end else begin
        wait_cnt[i] <= wait_cnt[i] + 1;
        mdis_ack_out[i] <= (wait_cnt[i] >= (i % 2 == 1 ? SLOW_DLY : 1));
      end
    end
  end
endmodule : bcg_master_model

//--- bench/tb_top.sv
// Self-checking bench for the branch clock manager over AXI4-Lite.
// Assumes bcg_pkg constants and the master model on the far side.
module tb_top
  import bcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'h0, rst_b = 1'h0, wake_ev = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid;
  logic [NUM_BRANCH-1:0] clk_en, mdis_req, mdis_ack, req_seen = '0;
  logic [NUM_BASE-1:0] base_idle;
  int fail_count = 0, check_count = 0;
  int ready_lag = 0;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) req_seen <= req_seen | mdis_req;

  bcg_branch_clock_manager bcg_branch_clock_manager_i (.ref_clk_in(ref_clk), .rst_b_in(rst_b),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata),
    .wstrb_in(wstrb), .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp),
    .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid),
    .rready_in(rready), .wake_event_in(wake_ev), .mdis_ack_in(mdis_ack),
    .clk_en_out(clk_en), .mdis_req_out(mdis_req), .base_idle_out(base_idle));
  bcg_master_model bcg_master_model_i (.ref_clk_in(ref_clk), .rst_b_in(rst_b),
    .mdis_req_in(mdis_req), .mdis_ack_out(mdis_ack));

  function automatic logic [ADDR_W-1:0] cfg_a(input int i, input logic [ADDR_W-1:0] base);
    return base + ADDR_W'(4 * i);
  endfunction : cfg_a

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare

  task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= dv;
    wstrb <= 4'hF;
    wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (awvalid && awready) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    repeat (ready_lag) @(posedge ref_clk);
    bready <= 1'h1;
    do @(posedge ref_clk); while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge ref_clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    repeat (ready_lag) @(posedge ref_clk);
    rready <= 1'h1;
    do @(posedge ref_clk); while (rvalid !== 1'h1);
    dv = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask : rd

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] dv);
    logic [1:0] resp;
    wr(a, dv, resp);
    compare({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask : wr_ok

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] dv;
    logic [1:0] resp;
    rd(a, dv, resp);
    compare(dv, exp);
  endtask : rd_chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'h1;
    @(posedge ref_clk);
    for (int i = 0; i < NUM_BRANCH; i++) rd_chk(cfg_a(i, OFS_CFG_BASE), 32'h1);
    rd_chk(OFS_BASE_STAT, 32'h0);
    compare({24'h0, clk_en}, 32'hFF);
    $display("test reset done");
    for (int i = 0; i < NUM_BRANCH; i++) begin
      wr_ok(cfg_a(i, OFS_CFG_BASE), 32'h7);
      rd_chk(cfg_a(i, OFS_CFG_BASE), (i == 0) ? 32'h1 : 32'h7);
      wr_ok(cfg_a(i, OFS_CFG_BASE), 32'h0);
      rd_chk(cfg_a(i, OFS_CFG_BASE), (i < 5) ? 32'h1 : 32'h0);
    end
    compare({24'h0, clk_en}, 32'h1F);
    rd_chk(cfg_a(5, OFS_STAT_BASE), 32'h0);
    $display("test tie-offs done");
    for (int i = 5; i < 7; i++) begin
      wr_ok(cfg_a(i, OFS_CFG_BASE), 32'h3);
      wr_ok(cfg_a(i, OFS_CFG_BASE), 32'h2);
      for (int n = 0; n < 50 && clk_en[i] !== 1'h0; n++) @(posedge ref_clk);
      compare({31'h0, req_seen[i]}, 32'h1);
      compare({31'h0, clk_en[i]}, 32'h0);
      wr_ok(cfg_a(i, OFS_CFG_BASE), 32'h1);
      rd_chk(cfg_a(i, OFS_STAT_BASE), 32'h1);
    end
    $display("test handshake done");
    wr_ok(cfg_a(1, OFS_CFG_BASE), 32'h1);
    wr_ok(cfg_a(2, OFS_CFG_BASE), 32'h5);
    wr_ok(cfg_a(7, OFS_CFG_BASE), 32'h1);
    wr_ok(OFS_POWER_MODE, 32'h1);
    rd_chk(OFS_POWER_MODE, 32'h1);
    rd(OFS_BASE_STAT, d, r);
    compare(d, 32'h4);
    compare({24'h0, clk_en}, 32'h05);
    wake_ev <= 1'h1;
    @(posedge ref_clk);
    wake_ev <= 1'h0;
    @(posedge ref_clk);
    rd_chk(OFS_POWER_MODE, 32'h0);
    compare({24'h0, clk_en}, 32'hFF);
    $display("test power-down done");
    // Late ready: responses must hold while waiting
    ready_lag = 3;
    wr(8'h10, 32'h1, r);
    compare({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(8'h10, d, r);
    compare({30'h0, r}, {30'h0, RESP_SLVERR});
    rd_chk(OFS_WAKE_EVENT, READ_ZERO);
    $display("test unmapped done");
    end_of_test();
  end

  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
endmodule : tb_top

bind bcg_branch_clock_manager bcg_checker bcg_checker_i (.ref_clk_in, .rst_b_in, .awvalid_in,
  .awready_out, .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in, .arvalid_in,
  .arready_out, .rdata_out, .rvalid_out, .rready_in, .clk_en_out, .mdis_req_out, .base_idle_out);
